// ===== src/hpe_params.svh
// offsets, field positions, reset values and timing counts of the hot-plug event block
`ifndef HPE_PARAMS_SVH
`define HPE_PARAMS_SVH
`define HPE_CLK_NS 20
`define HPE_TICK_NS 50000
`define HPE_BASE_NS 100000
`define HPE_TICK_CYCLES (`HPE_TICK_NS / `HPE_CLK_NS)
`define HPE_BASE_TICKS (`HPE_BASE_NS / `HPE_TICK_NS)
`define HPE_ADDR_CTL 16'h0C00
`define HPE_ADDR_STS 16'h0C01
`define HPE_ADDR_IEN 16'h0C02
`define HPE_ADDR_QUEUE 16'h0C03
`define HPE_ADDR_MIN 16'h0C04
`define HPE_ADDR_MAX 16'h0C05
`define HPE_ADDR_RISE_LO 16'h0C06
`define HPE_ADDR_RISE_HI 16'h0C07
`define HPE_ADDR_FALL_LO 16'h0C08
`define HPE_ADDR_FALL_HI 16'h0C09
`define HPE_ADDR_GEN 16'h0C0A
`define HPE_CTL_EN 0
`define HPE_CTL_DIR 1
`define HPE_CTL_GEN 2
`define HPE_CTL_VAL 3
`define HPE_CTL_LVL 7
`define HPE_STS_SHORT 0
`define HPE_STS_FALL 1
`define HPE_STS_RISE 2
`define HPE_STS_QNE 3
`define HPE_RST_BYTE 8'h00
`define HPE_RST_WORD 16'h0000
`endif

// ===== src/hpe_pkg.sv
// types shared by the hot-plug event block
package hpe_pkg;
	// qualifier states: settled low, settled high, low dip from high, high bump from low
	typedef enum logic [3:0] {
		HPE_ST_LOW = 4'h1,
		HPE_ST_HIGH = 4'h2,
		HPE_ST_DIP = 4'h4,
		HPE_ST_BUMP = 4'h8
	} hpe_det_state_e;
	// two-bit queue slot codes
	typedef enum logic [1:0] {
		HPE_SLOT_EMPTY = 2'h0,
		HPE_SLOT_RISE = 2'h1,
		HPE_SLOT_FALL = 2'h2,
		HPE_SLOT_SHORT = 2'h3
	} hpe_slot_code_e;
endpackage : hpe_pkg

// ===== src/hpe_evt_if.sv
// event pulses and settled line level from the qualifier to the core
`timescale 1ns/10ps
interface hpe_evt_if;
	logic rise_event; // one-cycle pulse
	logic fall_event; // one-cycle pulse
	logic short_pulse_event; // one-cycle pulse
	logic level; // settled line level
	modport det (output rise_event, output fall_event, output short_pulse_event, output level);
	modport core (input rise_event, input fall_event, input short_pulse_event, input level);
endinterface : hpe_evt_if

// ===== src/hpe_tick_gen.sv
// 50 us tick divider with a synchronous restart
`timescale 1ns/10ps
`include "hpe_params.svh"
module hpe_tick_gen import hpe_pkg::*; #(
	parameter int CYCLES = `HPE_TICK_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic restart_in,
	output logic tick_out
);
	localparam int W = $clog2(CYCLES);
	logic [W-1:0] cnt_r; // cycles into the current tick period
	logic [W-1:0] cnt_nxt;
	logic tick_nxt;
	// wrap at CYCLES-1; restart aligns the period to a pulse start
	always_comb begin
		cnt_nxt = cnt_r + W'(1);
		tick_nxt = 1'b0;
		if (restart_in) begin
			// restart edge counts as the first cycle, so n ticks end exactly n periods later
			cnt_nxt = W'(1);
		end else if (cnt_r == W'(CYCLES - 1)) begin
			cnt_nxt = '0;
			tick_nxt = 1'b1; // R21
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			cnt_r <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_out <= tick_nxt;
		end
	end
endmodule : hpe_tick_gen

// ===== src/hpe_line_qual.sv
// synchroniser and timing qualifier for the sensed hot-plug line
`timescale 1ns/10ps
`include "hpe_params.svh"
module hpe_line_qual import hpe_pkg::*; (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic line_raw_in,
	input wire logic [7:0] min_in,
	input wire logic [7:0] max_in,
	input wire logic [15:0] rise_in,
	input wire logic [15:0] fall_in,
	hpe_evt_if.det evt
);
	logic s1_r, s2_r, s3_r; // three-stage synchroniser
	logic lvl_r, lvl_nxt; // settled level
	hpe_det_state_e st_r, st_nxt;
	logic [16:0] cnt_r, cnt_nxt; // whole ticks spent in dip or bump
	logic rise_nxt, fall_nxt, short_nxt;
	logic [16:0] min_thr, max_thr, rise_thr, fall_thr;
	// every threshold carries the fixed 100 us base
	assign min_thr = {9'h000, min_in} + 17'(`HPE_BASE_TICKS); // R9
	assign max_thr = {9'h000, max_in} + 17'(`HPE_BASE_TICKS); // R11
	assign rise_thr = {1'h0, rise_in} + 17'(`HPE_BASE_TICKS);
	assign fall_thr = {1'h0, fall_in} + 17'(`HPE_BASE_TICKS);
	// a level counts once the second and third stages agree
	always_comb begin
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end
	// qualifier; starts from low so the first plug-in reports a rise
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		rise_nxt = 1'b0;
		fall_nxt = 1'b0;
		short_nxt = 1'b0;
		if (!run_in) begin
			st_nxt = HPE_ST_LOW;
			cnt_nxt = '0;
		end else begin
			case (st_r)
				HPE_ST_LOW: begin
					cnt_nxt = '0;
					if (lvl_r) st_nxt = HPE_ST_BUMP;
				end
				HPE_ST_BUMP: begin
					if (!lvl_r) begin
						st_nxt = HPE_ST_LOW; // too short a high, no rise
					end else if (tick_in && (cnt_r + 17'h1) >= rise_thr) begin
						st_nxt = HPE_ST_HIGH;
						rise_nxt = 1'b1; // R12
					end else if (tick_in) begin
						cnt_nxt = cnt_r + 17'h1;
					end
				end
				HPE_ST_HIGH: begin
					cnt_nxt = '0;
					if (!lvl_r) st_nxt = HPE_ST_DIP;
				end
				HPE_ST_DIP: begin
					if (lvl_r) begin
						st_nxt = HPE_ST_HIGH;
						// shorter than min is ignored, longer than max is no short pulse
						short_nxt = (cnt_r >= min_thr) && (cnt_r <= max_thr); // R10 R11
					end else if (tick_in && (cnt_r + 17'h1) >= fall_thr) begin
						st_nxt = HPE_ST_LOW;
						fall_nxt = 1'b1; // R13
					end else if (tick_in) begin
						cnt_nxt = cnt_r + 17'h1;
					end
				end
				default: st_nxt = HPE_ST_LOW;
			endcase
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
			st_r <= HPE_ST_LOW;
			cnt_r <= '0;
			evt.rise_event <= 1'b0;
			evt.fall_event <= 1'b0;
			evt.short_pulse_event <= 1'b0;
		end else begin
			s1_r <= line_raw_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			evt.rise_event <= rise_nxt;
			evt.fall_event <= fall_nxt;
			evt.short_pulse_event <= short_nxt;
		end
	end
	assign evt.level = lvl_r;
endmodule : hpe_line_qual

// ===== src/hpe_hot_plug_detector.sv
// hot-plug line event detector, queue and pulse generator with byte registers
// Notes on behaviour
// [R1] enable nibble bits gate matching interrupt sources
// [R2] first event after reset lands in slot zero
// [R3] writing 01b to a slot frees it
// [R4] new event goes after last filled slot
// [R5] store only into empty slot, wrap three-zero
// [R6] slot codes: empty, rise, fall, short pulse
// [R7] queue reads zero when disabled or output
// [R8] full queue drops further events
// [R9] minimum short pulse is 50us*field+100us
// [R10] lows shorter than minimum record nothing
// [R11] lows longer than maximum are no pulse
// [R12] rise after high for 50us*field+100us
// [R13] fall after low for 50us*field+100us
// [R14] generated pulse lasts field times 50us
// [R15] after pulse line returns to output value
// [R16] software keeps timing registers while enabled
// [R17] self-clearing generate bit starts output pulse
// [R18] direction bit: zero input, one output
// [R19] queue pending flag clears on queue read
// [R20] disabling clears interrupt status to zero
// [R21] 50us tick derived from system clock
`timescale 1ns/10ps
`include "hpe_params.svh"
module hpe_hot_plug_detector import hpe_pkg::*; #(
	parameter int TICK_CYCLES = `HPE_TICK_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic hot_plug_line_in,
	output logic hot_plug_line_out,
	output logic hot_plug_line_oe_out,
	output logic event_irq_out
);
	// address match, used by every strobe below
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction : hit

	hpe_evt_if evt ();
	logic tick; // 50 us enable pulse
	logic en_r, en_nxt; // line function enable
	logic dir_r, dir_nxt; // 1: driven output
	logic val_r, val_nxt; // idle output level
	logic busy_r, busy_nxt; // generate bit, self-clearing
	logic [7:0] gcnt_r, gcnt_nxt; // ticks of low left
	logic [3:0] ien_r, ien_nxt; // event_irq_enables
	logic [3:0] sts_r, sts_nxt; // interrupt status
	logic [7:0] queue_r, queue_nxt; // event_queue
	logic [1:0] ptr_r, ptr_nxt; // next slot to fill
	logic [7:0] min_r, min_nxt, max_r, max_nxt, gen_r, gen_nxt;
	logic [15:0] rise_r, rise_nxt, fall_r, fall_nxt;
	logic [7:0] rdata_nxt;
	logic line_nxt, oe_nxt, irq_nxt;
	logic gen_start, gen_restart, run, ev, store;
	logic [1:0] code;
	logic wr_ctl, wr_sts, wr_ien, wr_q, rd_q;

	assign wr_ctl = reg_wr_in && hit(reg_addr_in, `HPE_ADDR_CTL);
	assign wr_sts = reg_wr_in && hit(reg_addr_in, `HPE_ADDR_STS);
	assign wr_ien = reg_wr_in && hit(reg_addr_in, `HPE_ADDR_IEN);
	assign wr_q = reg_wr_in && hit(reg_addr_in, `HPE_ADDR_QUEUE);
	assign rd_q = reg_rd_in && hit(reg_addr_in, `HPE_ADDR_QUEUE) && run;
	assign run = en_r && !dir_r; // R18
	// generate bit taken only while enabled as output and idle
	assign gen_start = wr_ctl && reg_wdata_in[`HPE_CTL_GEN] && en_r && dir_r && !busy_r; // R17
	assign gen_restart = gen_start;

	hpe_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.restart_in(gen_restart),
		.tick_out(tick)
	);

	hpe_line_qual u_qual (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.run_in(run),
		.tick_in(tick),
		.line_raw_in(hot_plug_line_in),
		.min_in(min_r),
		.max_in(max_r),
		.rise_in(rise_r),
		.fall_in(fall_r),
		.evt(evt)
	);

	// detector pulses are mutually exclusive, so a plain priority encode is enough
	assign ev = evt.rise_event || evt.fall_event || evt.short_pulse_event;
	assign code = evt.rise_event ? HPE_SLOT_RISE : (evt.fall_event ? HPE_SLOT_FALL : HPE_SLOT_SHORT); // R6

	// control, timing and enable registers plus the pulse generator
	always_comb begin
		en_nxt = en_r;
		dir_nxt = dir_r;
		val_nxt = val_r;
		ien_nxt = ien_r;
		min_nxt = min_r;
		max_nxt = max_r;
		gen_nxt = gen_r;
		rise_nxt = rise_r;
		fall_nxt = fall_r;
		busy_nxt = busy_r;
		gcnt_nxt = gcnt_r;
		// timing writes are accepted at any time; changing them while enabled is unsafe
		if (reg_wr_in) begin
			if (hit(reg_addr_in, `HPE_ADDR_MIN)) min_nxt = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_MAX)) max_nxt = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_RISE_LO)) rise_nxt[7:0] = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_RISE_HI)) rise_nxt[15:8] = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_FALL_LO)) fall_nxt[7:0] = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_FALL_HI)) fall_nxt[15:8] = reg_wdata_in;
			else if (hit(reg_addr_in, `HPE_ADDR_GEN)) gen_nxt = reg_wdata_in;
		end
		if (wr_ien) ien_nxt = reg_wdata_in[3:0]; // R1
		if (wr_ctl) begin
			en_nxt = reg_wdata_in[`HPE_CTL_EN];
			dir_nxt = reg_wdata_in[`HPE_CTL_DIR]; // R18
			val_nxt = reg_wdata_in[`HPE_CTL_VAL];
		end
		if (gen_start && gen_r != 8'h00) begin
			busy_nxt = 1'b1; // R17
			gcnt_nxt = gen_r;
		end else if (busy_r && tick) begin
			// restart aligned the tick, so gen_r ticks is exactly the low time
			gcnt_nxt = gcnt_r - 8'h01;
			if (gcnt_r == 8'h01) busy_nxt = 1'b0; // R14
		end
		// leaving enable or output mode aborts a pulse
		if (!en_nxt || !dir_nxt) busy_nxt = 1'b0;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			en_r <= 1'b0;
			dir_r <= 1'b0;
			val_r <= 1'b0;
			busy_r <= 1'b0;
			gcnt_r <= `HPE_RST_BYTE;
			ien_r <= 4'h0;
			min_r <= `HPE_RST_BYTE;
			max_r <= `HPE_RST_BYTE;
			gen_r <= `HPE_RST_BYTE;
			rise_r <= `HPE_RST_WORD;
			fall_r <= `HPE_RST_WORD;
		end else begin
			en_r <= en_nxt;
			dir_r <= dir_nxt;
			val_r <= val_nxt;
			busy_r <= busy_nxt;
			gcnt_r <= gcnt_nxt;
			ien_r <= ien_nxt;
			min_r <= min_nxt;
			max_r <= max_nxt;
			gen_r <= gen_nxt;
			rise_r <= rise_nxt;
			fall_r <= fall_nxt;
		end
	end

	// event queue and sticky status; a set in the same cycle beats a clear, except the clear by disabling
	always_comb begin
		queue_nxt = queue_r;
		ptr_nxt = ptr_r;
		sts_nxt = sts_r;
		store = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (wr_q && reg_wdata_in[2*i +: 2] == HPE_SLOT_RISE) queue_nxt[2*i +: 2] = HPE_SLOT_EMPTY; // R3
		end
		if (wr_sts) sts_nxt[2:0] = sts_r[2:0] & ~reg_wdata_in[2:0];
		if (rd_q) sts_nxt[`HPE_STS_QNE] = 1'b0; // R19
		if (run && ev) begin
			sts_nxt[`HPE_STS_RISE] = sts_nxt[`HPE_STS_RISE] | evt.rise_event;
			sts_nxt[`HPE_STS_FALL] = sts_nxt[`HPE_STS_FALL] | evt.fall_event;
			sts_nxt[`HPE_STS_SHORT] = sts_nxt[`HPE_STS_SHORT] | evt.short_pulse_event;
			// always the slot after the last filled one, and only if empty
			if (queue_nxt[2*ptr_r +: 2] == HPE_SLOT_EMPTY) begin // R4 R5 R8
				store = 1'b1;
				queue_nxt[2*ptr_r +: 2] = code; // R6
				ptr_nxt = ptr_r + 2'h1; // R5
				sts_nxt[`HPE_STS_QNE] = 1'b1;
			end
		end
		// pulse finished in output mode reports on the short-pulse bit
		if (busy_r && !busy_nxt && en_nxt) sts_nxt[`HPE_STS_SHORT] = 1'b1;
		// disabling empties status, queue and pointer so a re-enable starts at slot zero
		if (!en_nxt) begin
			sts_nxt = 4'h0; // R20
			queue_nxt = `HPE_RST_BYTE;
			ptr_nxt = 2'h0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			queue_r <= `HPE_RST_BYTE;
			ptr_r <= 2'h0; // R2
			sts_r <= 4'h0;
		end else begin
			queue_r <= queue_nxt;
			ptr_r <= ptr_nxt;
			sts_r <= sts_nxt;
		end
	end

	// read mux and pin drivers, all registered
	always_comb begin
		rdata_nxt = reg_rdata_out;
		if (reg_rd_in) begin
			rdata_nxt = 8'h00; // unmapped addresses read zero
			if (hit(reg_addr_in, `HPE_ADDR_CTL)) begin
				rdata_nxt[`HPE_CTL_EN] = en_r;
				rdata_nxt[`HPE_CTL_DIR] = dir_r;
				rdata_nxt[`HPE_CTL_GEN] = busy_r && dir_r;
				rdata_nxt[`HPE_CTL_VAL] = val_r && dir_r;
				rdata_nxt[`HPE_CTL_LVL] = evt.level;
			end
			else if (hit(reg_addr_in, `HPE_ADDR_STS)) rdata_nxt = {4'h0, sts_r};
			else if (hit(reg_addr_in, `HPE_ADDR_IEN)) rdata_nxt = {4'h0, ien_r};
			else if (hit(reg_addr_in, `HPE_ADDR_QUEUE)) rdata_nxt = run ? queue_r : 8'h00; // R7
			else if (hit(reg_addr_in, `HPE_ADDR_MIN)) rdata_nxt = min_r;
			else if (hit(reg_addr_in, `HPE_ADDR_MAX)) rdata_nxt = max_r;
			else if (hit(reg_addr_in, `HPE_ADDR_RISE_LO)) rdata_nxt = rise_r[7:0];
			else if (hit(reg_addr_in, `HPE_ADDR_RISE_HI)) rdata_nxt = rise_r[15:8];
			else if (hit(reg_addr_in, `HPE_ADDR_FALL_LO)) rdata_nxt = fall_r[7:0];
			else if (hit(reg_addr_in, `HPE_ADDR_FALL_HI)) rdata_nxt = fall_r[15:8];
			else if (hit(reg_addr_in, `HPE_ADDR_GEN)) rdata_nxt = gen_r;
		end
		oe_nxt = en_nxt && dir_nxt; // R18
		line_nxt = val_nxt && !busy_nxt; // R14 R15
		irq_nxt = |(sts_nxt & ien_nxt); // R1
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 8'h00;
			hot_plug_line_out <= 1'b0;
			hot_plug_line_oe_out <= 1'b0;
			event_irq_out <= 1'b0;
		end else begin
			reg_rdata_out <= rdata_nxt;
			hot_plug_line_out <= line_nxt;
			hot_plug_line_oe_out <= oe_nxt;
			event_irq_out <= irq_nxt;
		end
	end

	// cycles the generated low has lasted; a counter instead of a long delay range
	logic [31:0] gen_cyc_r, gen_cyc_nxt;
	always_comb begin
		gen_cyc_nxt = gen_cyc_r;
		if (gen_start) gen_cyc_nxt = 32'h00000000;
		else if (busy_r) gen_cyc_nxt = gen_cyc_r + 32'h00000001;
	end
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			gen_cyc_r <= 32'h00000000;
		end else begin
			gen_cyc_r <= gen_cyc_nxt;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_gen_go;
		gen_start && gen_r != 8'h00;
	endsequence
	sequence s_gen_low;
		busy_r && !hot_plug_line_out;
	endsequence
	property p_irq_mask; // R1
		(sts_r & ien_r) == 4'h0 |-> !event_irq_out;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked status raised interrupt");
	property p_first_slot; // R2
		$fell(reset_in) |-> ptr_r == 2'h0 && queue_r == 8'h00;
	endproperty
	a_first_slot: assert property (@(posedge core_clk_in) p_first_slot) else $error("queue not empty after reset");
	property p_free_slot; // R3
		wr_q && reg_wdata_in[1:0] == 2'h1 && !(run && ev) && en_r && !wr_ctl |=> queue_r[1:0] == 2'h0;
	endproperty
	a_free_slot: assert property (p_free_slot) else $error("slot not freed by 01b write");
	property p_full_drop; // R8
		run && ev && queue_r[2*ptr_r +: 2] != 2'h0 && !wr_q && !wr_ctl |=> queue_r == $past(queue_r);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("event overwrote a filled slot");
	property p_code; // R6
		store && evt.fall_event && !wr_ctl |=> queue_r[2*$past(ptr_r) +: 2] == 2'h2 && ptr_r == $past(ptr_r) + 2'h1;
	endproperty
	a_code: assert property (p_code) else $error("fall event stored with wrong code");
	property p_queue_zero; // R7
		reg_rd_in && hit(reg_addr_in, `HPE_ADDR_QUEUE) && !run |=> reg_rdata_out == 8'h00;
	endproperty
	a_queue_zero: assert property (p_queue_zero) else $error("queue readable while not sensing");
	property p_pend_clear; // R19
		rd_q && !(run && ev) |=> !sts_r[`HPE_STS_QNE];
	endproperty
	a_pend_clear: assert property (p_pend_clear) else $error("pending flag survived queue read");
	property p_dis_clear; // R20
		!en_r |-> sts_r == 4'h0;
	endproperty
	a_dis_clear: assert property (p_dis_clear) else $error("status not cleared while disabled");
	property p_gen_pulse; // R14
		s_gen_go |=> s_gen_low;
	endproperty
	a_gen_pulse: assert property (p_gen_pulse) else $error("generated pulse did not start low");
	property p_gen_len; // R14
		$fell(busy_r) && en_r && dir_r |-> gen_cyc_r == 32'(gen_r) * 32'(TICK_CYCLES);
	endproperty
	a_gen_len: assert property (p_gen_len) else $error("generated pulse wrong length");
	property p_gen_end; // R15
		$fell(busy_r) && en_r && dir_r |-> hot_plug_line_out == val_r;
	endproperty
	a_gen_end: assert property (p_gen_end) else $error("line not back at output value");
endmodule : hpe_hot_plug_detector

// ===== tb/hpe_line_model.sv
// behavioural display device at the far end of the hot-plug line
`timescale 1ns/10ps
module hpe_line_model #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic core_clk_in,
	input wire logic line_drv_in, // level the block drives
	input wire logic line_oe_in, // block drives the line
	output logic line_lvl_out, // resolved line level
	output logic [15:0] low_width_out // cycles of the last driven low pulse
);
	logic sink_lvl_r; // level the far side drives while the block listens
	logic [15:0] low_cnt_r; // running length of a driven low
	// block wins while it drives; the far side owns the line otherwise
	assign line_lvl_out = line_oe_in ? line_drv_in : sink_lvl_r;
	initial begin
		sink_lvl_r = 1'b0;
		low_cnt_r = 16'h0000;
		low_width_out = 16'h0000;
	end
	// measure each low pulse the block drives, latched when it ends
	always @(posedge core_clk_in) begin
		if (line_oe_in && !line_drv_in) begin
			low_cnt_r <= low_cnt_r + 16'h0001;
		end else if (low_cnt_r != 16'h0000) begin
			low_width_out <= low_cnt_r;
			low_cnt_r <= 16'h0000;
		end
	end
	// hold one level for whole ticks, changed just after an edge
	task automatic hold(input logic lvl, input int ticks);
		@(posedge core_clk_in);
		sink_lvl_r <= lvl;
		repeat (ticks * TICK_CYCLES - 1) @(posedge core_clk_in);
	endtask : hold
endmodule : hpe_line_model

// ===== tb/test_hot_plug_event_detector.sv
// self-checking bench of the hot-plug event detector
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("ERROR %s expected %h seen %h", what, exp, got); \
		end \
	end
module test_hot_plug_event_detector;
	localparam int TICKS = 4; // short tick keeps the run brief
	// timing and enable setup: addresses, written data, read-back data
	localparam logic [15:0] CFG_A [8] = '{16'h0C02, 16'h0C04, 16'h0C05, 16'h0C06, 16'h0C07, 16'h0C08, 16'h0C09, 16'h0C0A};
	localparam logic [7:0] CFG_D [8] = '{8'hFF, 8'h01, 8'h03, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h05};
	localparam logic [7:0] CFG_E [8] = '{8'h0F, 8'h01, 8'h03, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h05};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata; // registered read data
	logic line_lvl; // resolved line
	logic line_drv; // block output level
	logic line_oe; // block output enable
	logic irq; // event interrupt
	logic [15:0] low_width; // measured generated pulse
	int error_cnt = 0;
	int checked = 0;
	hpe_hot_plug_detector #(.TICK_CYCLES(TICKS)) i_dut (.core_clk_in(clk), .reset_in(reset), .reg_addr_in(reg_addr),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
		.hot_plug_line_in(line_lvl), .hot_plug_line_out(line_drv), .hot_plug_line_oe_out(line_oe), .event_irq_out(irq));
	hpe_line_model #(.TICK_CYCLES(TICKS)) i_line (.core_clk_in(clk), .line_drv_in(line_drv), .line_oe_in(line_oe),
		.line_lvl_out(line_lvl), .low_width_out(low_width));
	// 50 MHz clock
	initial begin
		forever #10 clk = ~clk;
	end
	// one register write, strobe up for a single edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// one register read, data judged once it has settled
	task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHECK(what, exp, reg_rdata)
	endtask : rd_chk
	// let registered outputs follow the last write
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// a low of four ticks sits inside the short-pulse window
	task automatic short_pulse();
		i_line.hold(1'b0, 4);
		i_line.hold(1'b1, 4);
	endtask : short_pulse
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// reset values, unmapped place and timing setup while disabled
	task automatic t_regs();
		for (int i = 0; i < 12; i++) begin
			rd_chk("reset value", 16'h0C00 + 16'(i), 8'h00);
		end
		for (int i = 0; i < 8; i++) begin
			wr(CFG_A[i], CFG_D[i]);
			rd_chk("setup read-back", CFG_A[i], CFG_E[i]);
		end
		$display("test regs done");
	endtask : t_regs
	// rise, short pulse, long low and rise fill the queue in order; the glitch records nothing
	task automatic t_events();
		wr(16'h0C00, 8'h01);
		settle();
		`CHECK("line enable in input mode", 1'b0, line_oe)
		i_line.hold(1'b1, 6);
		rd_chk("status after rise", 16'h0C01, 8'h0C);
		`CHECK("irq after rise", 1'b1, irq)
		i_line.hold(1'b0, 1);
		i_line.hold(1'b1, 4);
		short_pulse();
		i_line.hold(1'b0, 14);
		i_line.hold(1'b1, 6);
		rd_chk("queue four events", 16'h0C03, 8'h6D);
		$display("test events done");
	endtask : t_events
	// full queue drops, freeing slots, pointer after last filled
	task automatic t_queue();
		short_pulse();
		rd_chk("queue when full", 16'h0C03, 8'h6D);
		rd_chk("pending flag after read", 16'h0C01, 8'h07);
		wr(16'h0C03, 8'h01);
		rd_chk("slot zero freed", 16'h0C03, 8'h6C);
		short_pulse();
		rd_chk("wrap into slot zero", 16'h0C03, 8'h6F);
		wr(16'h0C03, 8'h10);
		short_pulse();
		rd_chk("occupied next slot drops", 16'h0C03, 8'h4F);
		$display("test queue done");
	endtask : t_queue
	// enable nibble gates the interrupt
	task automatic t_irq();
		wr(16'h0C02, 8'h00);
		settle();
		`CHECK("irq with all masked", 1'b0, irq)
		wr(16'h0C02, 8'h04);
		settle();
		`CHECK("irq with rise enabled", 1'b1, irq)
		wr(16'h0C01, 8'h07);
		settle();
		`CHECK("irq after status clear", 1'b0, irq)
		rd_chk("status cleared", 16'h0C01, 8'h00);
		wr(16'h0C02, 8'h0F);
		$display("test irq done");
	endtask : t_irq
	// disabling empties the status and hides the queue
	task automatic t_disable();
		short_pulse();
		rd_chk("status short pulse", 16'h0C01, 8'h01);
		wr(16'h0C00, 8'h00);
		rd_chk("queue disabled", 16'h0C03, 8'h00);
		rd_chk("status disabled", 16'h0C01, 8'h00);
		$display("test disable done");
	endtask : t_disable
	// output mode and a generated low pulse of five ticks
	task automatic t_output();
		int n;
		wr(16'h0C00, 8'h0B);
		settle();
		`CHECK("drive enable in output mode", 1'b1, line_oe)
		`CHECK("idle output level", 1'b1, line_drv)
		rd_chk("queue in output mode", 16'h0C03, 8'h00);
		wr(16'h0C00, 8'h0F);
		#1;
		`CHECK("line low after generate", 1'b0, line_drv)
		n = 0;
		while (line_drv !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		settle();
		`CHECK("line back to output value", 1'b1, line_drv)
		`CHECK("pulse width in cycles", 16'(5 * TICKS), low_width)
		rd_chk("pulse done status", 16'h0C01, 8'h01);
		wr(16'h0C00, 8'h00);
		settle();
		`CHECK("drive released", 1'b0, line_oe)
		$display("test output done");
	endtask : t_output
	// main sequence: reset for twelve cycles, then the scenarios
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_events();
		t_queue();
		t_irq();
		t_disable();
		t_output();
		end_sim();
	end
	// watchdog: the scenarios need under five hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
endmodule : test_hot_plug_event_detector
